// ===== sepc_cfg.svh
// constants for the serial eeprom program control block
`ifndef SEPC_CFG_SVH
`define SEPC_CFG_SVH

// reference clock and timing figures
`define SEPC_CLK_NS 40
`define SEPC_SEL_LOW_NS 250
`define SEPC_PROG_TIME_NS 2000000

// instruction field widths
`define SEPC_OP_BITS 2
`define SEPC_ADDR16_BITS 10
`define SEPC_ADDR8_BITS 11
`define SEPC_W16 16
`define SEPC_W8 8
`define SEPC_WORDS 1024

// opcodes and extended codes in the top two address bits
`define SEPC_OP_EXT 2'h0
`define SEPC_OP_WRITE 2'h1
`define SEPC_OP_READ 2'h2
`define SEPC_OP_ERASE 2'h3
`define SEPC_EXT_DIS 2'h0
`define SEPC_EXT_WRITE_ARRAY_CMD 2'h1
`define SEPC_EXT_ERASE_ARRAY_CMD 2'h2
`define SEPC_EXT_EN 2'h3

// erased word value
`define SEPC_ERASED 16'hFFFF

`endif

// ===== sepc_pkg.sv
// types shared by the serial eeprom program control block
`default_nettype none
package sepc_pkg;

  // serial sequence states
  typedef enum logic [2:0] {
    ST_WAIT = 3'b000,
    ST_HEAD = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b011,
    ST_DONE = 3'b100
  } sepc_state_t;

  // kinds of self-timed programming
  typedef enum logic [1:0] {
    PG_WR = 2'b00,
    PG_ER = 2'b01,
    PG_WRITE_ARRAY_CMD = 2'b10,
    PG_ERASE_ARRAY_CMD = 2'b11
  } sepc_prog_t;

endpackage
`default_nettype wire

// ===== sepc_sync.sv
// two-flop synchroniser for the pins that enter the reference domain
`timescale 1ns/100ps
`default_nettype none
module sepc_sync #(
  parameter int unsigned W = 5
) (
  input wire logic ref_clk_i, // reference clock
  input wire logic rst_n_i, // released reset, active low
  input wire logic [W-1:0] d_i, // asynchronous pin levels
  output logic [W-1:0] q_o // synchronised levels
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule
`default_nettype wire

// ===== sepc_top.sv
// serial eeprom command, read and programming control
`timescale 1ns/100ps
`default_nettype none
`include "sepc_cfg.svh"
// Overview of operation
// - after power-up writes are disabled until the enable command runs
// - enable latch stays set until the disable command or power loss
// - reads work whatever the enable latch holds
// - read sends one zero bit, then an 8-bit or 16-bit word
// - select held high keeps reading the following locations
// - bits sampled and data out changed on rising serial clock
// - low-voltage variant starts programming at select falling edge
// - 5 V variant starts programming on the last instruction clock edge
// - select high after 250 ns low shows busy low, ready high
// - write-all erases then writes every word, only when enabled
// - programming completes with no serial clock edges
// - start bit then select low clears the ready indication
// - select low gives standby only once programming is over
// - select low at least 250 ns; low select resets control logic
// - serial clock may pause at any level without losing state
// - low data in with select high never forms a start
// - after a full instruction clock and data are ignored
// - select low for whole cycle keeps output off; later shows ready
// - organization high picks 16-bit words, low picks 8-bit words
// - array writes need enable latch and program enable pin high
// - start is first rising clock with select and data in high
// - instruction runs only after all its bits are shifted in
// - single-word erase sets every bit of the word to one
module sepc_top #(
  parameter int unsigned PROG_CYC = `SEPC_PROG_TIME_NS / `SEPC_CLK_NS,
  parameter bit HAS_ORG_PIN = 1'b1, // variant has organization pin
  parameter bit FIXED_X16 = 1'b0, // word size without the pin
  parameter bit HAS_PE_PIN = 1'b1, // variant has program enable pin
  parameter bit LOW_VOLT = 1'b1 // start on select fall, else on clock
) (
  input wire logic ref_clk_i, // 25 MHz reference clock
  input wire logic rst_n_i, // power-on reset, active low
  input wire logic sel_i, // chip select pin, high selects
  input wire logic sclk_i, // serial clock pin
  input wire logic serial_in_i, // serial data in pin
  input wire logic organization_select_i, // high for 16-bit words
  input wire logic program_enable_pin_i, // high allows array writes
  output logic dout_o, // serial data out level
  output logic dout_oe_n_o, // low while data out is driven
  output logic busy_o, // self-timed programming running
  output logic standby_o, // deselected and idle
  output logic write_enabled_o // enable latch state
);
  import sepc_pkg::*;

  localparam logic [4:0] HEAD16_LAST =
    5'(`SEPC_OP_BITS + `SEPC_ADDR16_BITS - 1);
  localparam logic [4:0] HEAD8_LAST =
    5'(`SEPC_OP_BITS + `SEPC_ADDR8_BITS - 1);
  localparam logic [4:0] LEN16 = 5'(`SEPC_W16);
  localparam logic [4:0] LEN8 = 5'(`SEPC_W8);
  localparam logic [3:0] SEL_LOW_CYC =
    4'((`SEPC_SEL_LOW_NS + `SEPC_CLK_NS - 1) / `SEPC_CLK_NS);
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisation

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [4:0] pins_s;
  logic sel_s, sclk_s, din_s, org_s, pe_s;

  // asynchronous assert, release after two edges
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_r[1];

  sepc_sync #(.W(5)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .d_i({sel_i, sclk_i, serial_in_i, organization_select_i,
          program_enable_pin_i}),
    .q_o(pins_s)
  );
  assign {sel_s, sclk_s, din_s, org_s, pe_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////
  // edge finding and decoding helpers

  logic sclk_d_r, sel_d_r;
  logic rise, sel_fall, x16, pe_ok;
  logic [4:0] head_last, data_len;

  // edges only, so a paused clock simply stalls the sequence
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'h0;
      sel_d_r <= 1'h0;
    end else begin
      sclk_d_r <= sclk_s;
      sel_d_r <= sel_s;
    end
  end
  assign rise = sclk_s & ~sclk_d_r & sel_s;
  assign sel_fall = sel_d_r & ~sel_s;
  assign x16 = HAS_ORG_PIN ? org_s : FIXED_X16;
  assign pe_ok = HAS_PE_PIN ? pe_s : 1'h1;
  assign head_last = x16 ? HEAD16_LAST : HEAD8_LAST;
  assign data_len = x16 ? LEN16 : LEN8;

  // word index of a byte or word address
  function automatic logic [9:0] idx_of(input logic [10:0] a,
                                        input logic x);
    return x ? a[9:0] : a[10:1];
  endfunction

  // stored word left-justified for the read shifter
  function automatic logic [15:0] word_of(input logic [15:0] w,
                                          input logic [10:0] a,
                                          input logic x);
    return x ? w : {(a[0] ? w[15:8] : w[7:0]), 8'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // instruction decode

  sepc_state_t state_r;
  logic [4:0] cnt_r;
  logic [12:0] head_r;
  logic [15:0] data_r;
  logic [15:0] mem_r [`SEPC_WORDS];
  logic [12:0] hd_full;
  logic [15:0] dt_full;
  logic [1:0] op, ext;
  logic [10:0] adr;
  logic head_done, data_done, is_read, is_en, is_dis;
  logic issue, issue_ok;
  sepc_prog_t issue_kind;
  logic wen_r, busy_r;
  logic [1:0] op_hold_r;

  assign hd_full = {head_r[11:0], din_s};
  assign dt_full = {data_r[14:0], din_s};
  assign op = x16 ? hd_full[11:10] : hd_full[12:11];
  assign ext = x16 ? hd_full[9:8] : hd_full[10:9];
  assign adr = x16 ? {1'h0, hd_full[9:0]} : hd_full[10:0];
  assign head_done = rise && state_r == ST_HEAD && cnt_r == head_last;
  assign data_done = rise && state_r == ST_DATA &&
                     cnt_r == data_len - 5'h01;
  assign is_read = head_done && op == `SEPC_OP_READ;
  assign is_en = head_done && op == `SEPC_OP_EXT && ext == `SEPC_EXT_EN;
  assign is_dis = head_done && op == `SEPC_OP_EXT &&
                  ext == `SEPC_EXT_DIS;

  // programming requests: erase at end of header, writes after data
  always_comb begin
    issue = 1'h0;
    issue_kind = PG_WR;
    if (head_done && op == `SEPC_OP_ERASE) begin
      issue = 1'h1;
      issue_kind = PG_ER;
    end else if (head_done && op == `SEPC_OP_EXT &&
                 ext == `SEPC_EXT_ERASE_ARRAY_CMD) begin
      issue = 1'h1;
      issue_kind = PG_ERASE_ARRAY_CMD;
    end else if (data_done) begin
      issue = 1'h1;
      issue_kind = PG_WR;
      if (op_hold_r == `SEPC_OP_EXT) begin
        issue_kind = PG_WRITE_ARRAY_CMD;
      end
    end
  end
  // refused while the latch or pin blocks, or a cycle is running
  assign issue_ok = issue && wen_r && pe_ok && !busy_r;

  // serial sequence; select low holds it in reset
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_WAIT;
      cnt_r <= 5'h00;
      head_r <= 13'h0000;
      data_r <= 16'h0000;
      op_hold_r <= 2'h0;
    end else if (!sel_s) begin
      state_r <= ST_WAIT;
      cnt_r <= 5'h00;
    end else if (rise) begin
      unique case (state_r)
        ST_WAIT: begin
          if (din_s) begin
            state_r <= ST_HEAD;
            cnt_r <= 5'h00;
            head_r <= 13'h0000;
          end
        end
        ST_HEAD: begin
          head_r <= hd_full;
          cnt_r <= cnt_r + 5'h01;
          if (head_done) begin
            op_hold_r <= op;
            cnt_r <= 5'h00;
            if (is_read) begin
              state_r <= ST_READ;
            end else if (op == `SEPC_OP_WRITE || (op == `SEPC_OP_EXT &&
                         ext == `SEPC_EXT_WRITE_ARRAY_CMD)) begin
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DATA: begin
          data_r <= dt_full;
          cnt_r <= cnt_r + 5'h01;
          if (data_done) begin
            state_r <= ST_DONE;
          end
        end
        ST_READ: state_r <= ST_READ;
        ST_DONE: state_r <= ST_DONE;
        default: state_r <= ST_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable latch, kept across select cycles

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wen_r <= 1'h0;
    end else if (is_en) begin
      wen_r <= 1'h1;
    end else if (is_dis) begin
      wen_r <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed programming, runs on the reference clock alone

  logic pend_r, pg_x16_r;
  logic [31:0] prog_cnt_r;
  sepc_prog_t pg_kind_r, pend_kind_r;
  logic [10:0] pg_addr_r;
  logic [15:0] pg_data_r;
  logic start_prog, pg_commit;

  assign start_prog = LOW_VOLT ? (pend_r && sel_fall)
                               : issue_ok;
  assign pg_commit = busy_r && prog_cnt_r == PROG_LAST;

  // the request is frozen at issue so select low cannot disturb it
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'h0;
      pend_kind_r <= PG_WR;
      pg_kind_r <= PG_WR;
      pg_addr_r <= 11'h000;
      pg_data_r <= 16'h0000;
      pg_x16_r <= 1'h0;
    end else if (issue_ok) begin
      pend_r <= 1'h1;
      pg_kind_r <= issue_kind;
      // op is only valid at header end, so decide by the request kind
      pg_addr_r <= (issue_kind == PG_ER) ? adr : head_r[10:0] &
                   (x16 ? 11'h3FF : 11'h7FF);
      pg_data_r <= dt_full;
      pg_x16_r <= x16;
    end else if (sel_fall) begin
      pend_r <= 1'h0;
    end
  end

  // busy counter; finishes whatever select does
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'h0;
      prog_cnt_r <= 32'h0000_0000;
    end else if (start_prog) begin
      busy_r <= 1'h1;
      prog_cnt_r <= 32'h0000_0000;
    end else if (pg_commit) begin
      busy_r <= 1'h0;
    end else if (busy_r) begin
      prog_cnt_r <= prog_cnt_r + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array storage, one process per word

  logic pg_all, pg_erase;
  logic [15:0] pat16;

  assign pg_all = pg_kind_r == PG_WRITE_ARRAY_CMD || pg_kind_r == PG_ERASE_ARRAY_CMD;
  assign pg_erase = pg_kind_r == PG_ER || pg_kind_r == PG_ERASE_ARRAY_CMD;
  // erase yields all ones; write-all overwrites the erased word
  assign pat16 = pg_erase ? `SEPC_ERASED :
                 (pg_x16_r ? pg_data_r
                           : {pg_data_r[7:0], pg_data_r[7:0]});

  generate
    for (genvar i = 0; i < `SEPC_WORDS; i++) begin : g_word
      // contents survive reset, as nonvolatile storage should
      always_ff @(posedge ref_clk_i) begin
        if (pg_commit && (pg_all || idx_of(pg_addr_r, pg_x16_r) ==
            10'(i))) begin
          if (pg_all || pg_x16_r) begin
            mem_r[i] <= pat16;
          end else if (pg_addr_r[0]) begin
            mem_r[i][15:8] <= pat16[7:0];
          end else begin
            mem_r[i][7:0] <= pat16[7:0];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read shifter

  logic [10:0] rd_addr_r, nxt_addr;
  logic [15:0] rd_sh_r, rd_new;
  logic [4:0] rd_left_r;
  logic rd_bit_r;

  assign nxt_addr = x16 ? {1'h0, rd_addr_r[9:0] + 10'h001}
                        : rd_addr_r + 11'h001;
  assign rd_new = word_of(mem_r[idx_of(nxt_addr, x16)], nxt_addr, x16);

  // dummy zero first, then msb first; wraps into the next word
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_r <= 11'h000;
      rd_sh_r <= 16'h0000;
      rd_left_r <= 5'h00;
      rd_bit_r <= 1'h0;
    end else if (is_read) begin
      rd_addr_r <= adr;
      rd_sh_r <= word_of(mem_r[idx_of(adr, x16)], adr, x16);
      rd_left_r <= data_len;
      rd_bit_r <= 1'h0;
    end else if (rise && state_r == ST_READ) begin
      if (rd_left_r != 5'h00) begin
        rd_bit_r <= rd_sh_r[15];
        rd_sh_r <= {rd_sh_r[14:0], 1'h0};
        rd_left_r <= rd_left_r - 5'h01;
      end else begin
        rd_addr_r <= nxt_addr;
        rd_bit_r <= rd_new[15];
        rd_sh_r <= {rd_new[14:0], 1'h0};
        rd_left_r <= data_len - 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ready/busy status and output pins

  logic armed_r, clr_pend_r;
  logic [3:0] low_cnt_r;
  logic low_ok, show_stat;

  assign low_ok = low_cnt_r >= SEL_LOW_CYC;
  assign show_stat = sel_s && armed_r && low_ok && state_r != ST_READ;

  // low time of the last deselect, frozen while selected
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= 4'h0;
    end else if (sel_fall) begin
      low_cnt_r <= 4'h1;
    end else if (!sel_s && !low_ok) begin
      low_cnt_r <= low_cnt_r + 4'h1;
    end
  end

  // status stays armed until a start bit and select low, once ready
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'h0;
      clr_pend_r <= 1'h0;
    end else begin
      if (start_prog) begin
        armed_r <= 1'h1;
      end else if (clr_pend_r && sel_fall && !busy_r) begin
        armed_r <= 1'h0;
      end
      if (start_prog || !sel_s) begin
        clr_pend_r <= 1'h0;
      end else if (rise && state_r == ST_WAIT && din_s && !busy_r) begin
        clr_pend_r <= 1'h1;
      end
    end
  end

  // registered pins; off whenever deselected
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dout_o <= 1'h1;
      dout_oe_n_o <= 1'h1;
      standby_o <= 1'h1;
      write_enabled_o <= 1'h0;
    end else begin
      write_enabled_o <= wen_r;
      standby_o <= !sel_s && !busy_r;
      if (sel_s && state_r == ST_READ) begin
        dout_o <= rd_bit_r;
        dout_oe_n_o <= 1'h0;
      end else if (show_stat) begin
        dout_o <= !busy_r;
        dout_oe_n_o <= 1'h0;
      end else begin
        dout_o <= 1'h1;
        dout_oe_n_o <= 1'h1;
      end
    end
  end
  assign busy_o = busy_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_no_false_start: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) (sel_s && state_r == ST_WAIT && !din_s) |=>
    state_r == ST_WAIT) else $error("start seen with data low");
  a_cs_low_reset: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) !sel_s |=> state_r == ST_WAIT && dout_oe_n_o)
    else $error("control not reset by select low");
  a_write_gated: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) start_prog |-> wen_r)
    else $error("write accepted while inhibited");
  a_refused_idle: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) (issue && !wen_r && !busy_r) |=> !busy_r && !pend_r)
    else $error("refused write started a cycle");
  a_busy_holds: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) (busy_r && prog_cnt_r != PROG_LAST) |=> busy_r)
    else $error("programming cut short");
  a_dummy_zero: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) (is_read && sel_s) |=> !rd_bit_r ##1
    (!sel_s || (!dout_oe_n_o && !dout_o)))
    else $error("read did not lead with zero");
  a_status_level: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) show_stat |=> !dout_oe_n_o && dout_o == !$past(busy_r))
    else $error("ready/busy level wrong");
  a_latch_keeps: assert property (@(posedge ref_clk_i) disable iff
    (!rst_n) (wen_r && !is_dis) |=> wen_r)
    else $error("enable latch lost");

endmodule
`default_nettype wire

// ===== sepc_master.sv
// serial bus master model driving select, clock and data in
`timescale 1ns/100ps
`default_nettype none
module sepc_master (
  input wire logic ref_clk_i, // reference clock for pacing
  input wire logic dout_i, // device data out
  input wire logic dout_oe_n_i, // low while device drives
  output logic sel_o, // chip select
  output logic sclk_o, // serial clock, still between frames
  output logic sdi_o // serial data in
);
  ////////////////////////////////////////
  // pins idle low from time zero
  initial begin
    sel_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // pacing on falling edges keeps changes clear of the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // lead zero clocks, n bits msb first, then nrd read clocks
  task automatic frame(input int lead, input int n, input logic [31:0] v,
    input int nrd, input int pz, output logic [32:0] rd);
    int i;
    rd = '0;
    tick(1);
    sel_o = 1'b1;
    for (i = 0; i < lead + n + nrd; i++) begin
      // zeros before the start bit must be ignored
      sdi_o = (i >= lead && i < lead + n) ? v[lead + n - 1 - i] : 1'b0;
      tick(4);
      if (i >= lead + n) rd = {rd[31:0], dout_i};
      sclk_o = 1'b1;
      tick((i % 5 == 2) ? 4 + pz : 4);
      sclk_o = 1'b0;
    end
    if (nrd > 0) begin
      tick(4);
      rd = {rd[31:0], dout_i};
    end
    sel_o = 1'b0;
    sdi_o = ~sdi_o;
    tick(10);
  endtask

  // select high with the clock stopped; count busy cycles until ready
  task automatic poll(output int nb, output bit ok);
    int k;
    nb = 0;
    ok = 1'b0;
    sel_o = 1'b1;
    tick(8);
    for (k = 0; k < 200 && !ok; k++) begin
      if (dout_oe_n_i === 1'b0 && dout_i === 1'b0) nb++;
      if (dout_oe_n_i === 1'b0 && dout_i === 1'b1) ok = 1'b1;
      if (!ok) tick(1);
    end
    sel_o = 1'b0;
    tick(10);
  endtask

  // brief select pulse to look at the output enable
  task automatic peek(output logic oe);
    sel_o = 1'b1;
    tick(8);
    oe = dout_oe_n_i;
    sel_o = 1'b0;
    tick(10);
  endtask
endmodule
`default_nettype wire

// ===== test_serial_eeprom_program_control.sv
// self-checking bench for the serial eeprom program control block
`timescale 1ns/100ps
`default_nettype none
`include "sepc_cfg.svh"
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module test_serial_eeprom_program_control;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic organization_select = 1'b1;
  logic pe = 1'b1;
  logic sel, sclk, sdi, dout, oe_n, busy, stby, wen, oe, busy5;
  logic [15:0] mem [1024];
  logic [31:0] seed = 32'h25D0B6EB;
  logic [32:0] rd;
  logic [15:0] d;
  logic [10:0] a;
  int n_errors = 0;
  int compares = 0;
  int nb, k;
  bit ok;

  ////////////////////////////////////////
  // reference clock, 40 ns period
  always #20 ref_clk_i = ~ref_clk_i;

  // short programming time keeps busy polls brief
  sepc_top #(.PROG_CYC(20)) dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(sel),
    .sclk_i(sclk),
    .serial_in_i(sdi),
    .organization_select_i(organization_select),
    .program_enable_pin_i(pe),
    .dout_o(dout),
    .dout_oe_n_o(oe_n),
    .busy_o(busy),
    .standby_o(stby),
    .write_enabled_o(wen)
  );

  // 5 V variant on the same pins: programming starts on the last clock
  sepc_top #(.PROG_CYC(20), .LOW_VOLT(1'b0)) dut_5v (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(sel),
    .sclk_i(sclk),
    .serial_in_i(sdi),
    .organization_select_i(organization_select),
    .program_enable_pin_i(pe),
    .dout_o(),
    .dout_oe_n_o(),
    .busy_o(busy5),
    .standby_o(),
    .write_enabled_o()
  );

  // far-side master on the serial pins
  sepc_master m (
    .ref_clk_i(ref_clk_i),
    .dout_i(dout),
    .dout_oe_n_i(oe_n),
    .sel_o(sel),
    .sclk_o(sclk),
    .sdi_o(sdi)
  );

  // lfsr step for repeatable stimulus
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // address field carrying an extended code
  function automatic logic [10:0] xa(input logic [1:0] c);
    return organization_select ? {1'b0, c, 8'h00} : {c, 9'h000};
  endfunction

  // value the model expects at a location
  function automatic logic [15:0] ex(input logic [10:0] ad);
    if (organization_select) return mem[ad[9:0]];
    return {8'h00, ad[0] ? mem[ad[10:1]][15:8] : mem[ad[10:1]][7:0]};
  endfunction

  // model update; in byte mode the odd address is the high byte
  task automatic put(input logic [10:0] ad, input logic [15:0] dw);
    if (organization_select) mem[ad[9:0]] = dw;
    else if (ad[0]) mem[ad[10:1]][15:8] = dw[7:0];
    else mem[ad[10:1]][7:0] = dw[7:0];
  endtask

  // one instruction: header, optional data word, read clocks
  task automatic cmd(input logic [1:0] op, input logic [10:0] ad,
    input logic [15:0] dw, input bit wd, input int nrd);
    logic [31:0] v;
    int n;
    v = organization_select ? {19'h0, 1'b1, op, ad[9:0]} : {18'h0, 1'b1, op, ad};
    n = organization_select ? 13 : 14;
    if (wd) v = organization_select ? {v[15:0], dw} : {v[23:0], dw[7:0]};
    if (wd) n = n + (organization_select ? 16 : 8);
    m.frame(rnd() % 3, n, v, nrd, rnd() % 4, rd);
  endtask

  // programming instruction then a status poll
  task automatic wr(input logic [1:0] op, input logic [10:0] ad,
    input logic [15:0] dw, input bit wd, input bit go);
    cmd(op, ad, dw, wd, 0);
    m.poll(nb, ok);
    if (go) begin
      `CHK(nb > 0, 1'b1)
      `CHK(ok, 1'b1)
    end else begin
      `CHK(nb, 0)
    end
    `CHK(busy, 1'b0)
  endtask

  // two locations in one read frame against the model
  task automatic rdchk(input logic [10:0] ad);
    int w;
    w = organization_select ? 16 : 8;
    cmd(`SEPC_OP_READ, ad, 16'h0000, 1'b0, 2 * w);
    `CHK(rd[2 * w], 1'b0)
    `CHK(organization_select ? rd[31:16] : {8'h00, rd[15:8]}, ex(ad))
    `CHK(organization_select ? rd[15:0] : {8'h00, rd[7:0]}, ex(ad + 11'h001))
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    `CHK(wen, 1'b0)
    `CHK(stby, 1'b1)
    `CHK(oe_n, 1'b1)
    wr(`SEPC_OP_EXT, xa(`SEPC_EXT_WRITE_ARRAY_CMD), 16'h1234, 1'b1, 1'b0);
    cmd(`SEPC_OP_EXT, xa(`SEPC_EXT_EN), 16'h0000, 1'b0, 0);
    `CHK(wen, 1'b1)
    $display("test power-up protection done");
    d = 16'(rnd());
    wr(`SEPC_OP_EXT, xa(`SEPC_EXT_WRITE_ARRAY_CMD), d, 1'b1, 1'b1);
    for (k = 0; k < 1024; k++) mem[k] = d;
    rdchk(11'(rnd() % 1023));
    // random words in both organizations
    repeat (6) begin
      d = 16'(rnd());
      organization_select = d[0];
      a = organization_select ? 11'(rnd() % 1023) : 11'(rnd() % 2047);
      d = 16'(rnd());
      wr(`SEPC_OP_WRITE, a, d, 1'b1, 1'b1);
      put(a, d);
      rdchk(a);
    end
    $display("test write and read done");
    organization_select = 1'b1;
    pe = 1'b0;
    a = 11'(rnd() % 1023);
    wr(`SEPC_OP_WRITE, a, ~ex(a), 1'b1, 1'b0);
    `CHK(wen, 1'b1)
    pe = 1'b1;
    rdchk(a);
    wr(`SEPC_OP_ERASE, a, 16'h0000, 1'b0, 1'b1);
    put(a, 16'hFFFF);
    rdchk(a);
    wr(`SEPC_OP_EXT, xa(`SEPC_EXT_ERASE_ARRAY_CMD), 16'h0000, 1'b0, 1'b1);
    for (k = 0; k < 1024; k++) mem[k] = 16'hFFFF;
    rdchk(11'(rnd() % 1023));
    $display("test protection and erase done");
    // programming with select low throughout
    d = 16'(rnd());
    cmd(`SEPC_OP_WRITE, a, d, 1'b1, 0);
    `CHK(busy, 1'b1)
    `CHK(busy5, 1'b1)
    `CHK(stby, 1'b0)
    `CHK(oe_n, 1'b1)
    // the 5 V copy started on the last clock, so it must finish first
    for (k = 0; k < 100 && busy5 !== 1'b0; k++) @(negedge ref_clk_i);
    `CHK(busy5, 1'b0)
    `CHK(busy, 1'b1)
    for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge ref_clk_i);
    if (busy !== 1'b0) begin
      n_errors++;
      wrap_up();
    end
    // standby is registered one cycle behind busy
    @(negedge ref_clk_i);
    `CHK(stby, 1'b1)
    m.poll(nb, ok);
    `CHK(nb, 0)
    `CHK(ok, 1'b1)
    put(a, d);
    m.frame(0, 1, 32'h0000_0001, 0, 0, rd);
    m.peek(oe);
    `CHK(oe, 1'b1)
    cmd(`SEPC_OP_EXT, xa(`SEPC_EXT_DIS), 16'h0000, 1'b0, 0);
    `CHK(wen, 1'b0)
    wr(`SEPC_OP_WRITE, a, ~d, 1'b1, 1'b0);
    rdchk(a);
    $display("test standby and disable done");
    wrap_up();
  end
endmodule
`default_nettype wire
